/* File: bts_pkg.sv */
// shared constants, types and decode functions for the boundary-scan test port
package bts_pkg;

    // ****************************************
    // chain geometry
    // ****************************************
    localparam int IN_W      = 8;                   // functional input pins
    localparam int OUT_W     = 8;                   // functional output pins
    localparam int CHAIN_LEN = IN_W + OUT_W + 1;    // inputs, outputs, one drive-enable cell
    localparam int OUT_LSB   = IN_W;
    localparam int OUT_MSB   = IN_W + OUT_W - 1;
    localparam int CTRL_POS  = CHAIN_LEN - 1;
    localparam int IR_W      = 4;
    localparam int ID_W      = 32;

    // ****************************************
    // instruction codes
    // ****************************************
    localparam logic [IR_W-1:0] C_EXTEST  = 4'h0;
    localparam logic [IR_W-1:0] C_SAMPLE  = 4'h1;
    localparam logic [IR_W-1:0] C_IDCODE  = 4'h2;
    localparam logic [IR_W-1:0] C_CLAMP   = 4'h3;
    localparam logic [IR_W-1:0] C_HIGHZ   = 4'h4;
    localparam logic [IR_W-1:0] C_BYPASS  = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPT   = 4'h1;   // low bits read 01

    // ****************************************
    // identity word fields and reset values
    // ****************************************
    localparam int REV_LSB  = 28;
    localparam int PART_LSB = 12;
    localparam int MFR_LSB  = 1;
    localparam logic [3:0]  ID_REV_DEF  = 4'h5;     // arbitrary value
    localparam logic [15:0] ID_PART_DEF = 16'ha5c3; // arbitrary value
    localparam logic [10:0] ID_MFR_DEF  = 11'h2b5;  // arbitrary value
    localparam logic        ID_MARK     = 1'b1;
    localparam logic [CHAIN_LEN-1:0] CHAIN_RST = '0;

    // ****************************************
    // controller states, one-hot
    // ****************************************
    typedef enum logic [15:0] {
        S_TLR   = 16'h0001,
        S_RTI   = 16'h0002,
        S_SELDR = 16'h0004,
        S_CAPDR = 16'h0008,
        S_SHDR  = 16'h0010,
        S_EX1DR = 16'h0020,
        S_PADR  = 16'h0040,
        S_EX2DR = 16'h0080,
        S_UPDR  = 16'h0100,
        S_SELIR = 16'h0200,
        S_CAPIR = 16'h0400,
        S_SHIR  = 16'h0800,
        S_EX1IR = 16'h1000,
        S_PAIR  = 16'h2000,
        S_EX2IR = 16'h4000,
        S_UPIR  = 16'h8000
    } bts_tap_state_t;

    // instruction routes the pin cell chain between data in and out
    function automatic logic bts_sel_chain(input logic [IR_W-1:0] code);
        return (code == C_EXTEST) || (code == C_SAMPLE);
    endfunction : bts_sel_chain

    // instruction puts the boundary cells onto the output pins
    function automatic logic bts_drive_cells(input logic [IR_W-1:0] code);
        return (code == C_EXTEST) || (code == C_CLAMP);
    endfunction : bts_drive_cells

endpackage : bts_pkg

/* File: bts_tap_fsm.sv */
// sixteen-state test access controller stepped by sampled test clock rises
`timescale 1ns/10ps
module bts_tap_fsm
    import bts_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst_b,
    input  wire logic           tap_rst_b,  // synchronised test reset
    input  wire logic           step,       // one-cycle pulse per test clock rise
    input  wire logic           tms,        // synchronised mode select
    output bts_pkg::bts_tap_state_t state
);
    import bts_pkg::*;

    bts_tap_state_t next_state;

    // next state on the mode select level
    function automatic bts_tap_state_t tap_next(input bts_tap_state_t s, input logic m);
        unique case (s)
            S_TLR:   return m ? S_TLR   : S_RTI;
            S_RTI:   return m ? S_SELDR : S_RTI;
            S_SELDR: return m ? S_SELIR : S_CAPDR;
            S_CAPDR: return m ? S_EX1DR : S_SHDR;
            S_SHDR:  return m ? S_EX1DR : S_SHDR;
            S_EX1DR: return m ? S_UPDR  : S_PADR;
            S_PADR:  return m ? S_EX2DR : S_PADR;
            S_EX2DR: return m ? S_UPDR  : S_SHDR;
            S_UPDR:  return m ? S_SELDR : S_RTI;
            S_SELIR: return m ? S_TLR   : S_CAPIR;
            S_CAPIR: return m ? S_EX1IR : S_SHIR;
            S_SHIR:  return m ? S_EX1IR : S_SHIR;
            S_EX1IR: return m ? S_UPIR  : S_PAIR;
            S_PAIR:  return m ? S_EX2IR : S_PAIR;
            S_EX2IR: return m ? S_UPIR  : S_SHIR;
            S_UPIR:  return m ? S_SELDR : S_RTI;
            default: return S_TLR;      // an illegal code falls back to reset
        endcase
    endfunction : tap_next

    // test reset wins over stepping
    always_comb
    begin
        next_state = state;
        if (!tap_rst_b)
            next_state = S_TLR;                 // RULE14
        else if (step)
            next_state = tap_next(state, tms);  // RULE14
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= S_TLR;
        else
            state <= next_state;
    end

    // ****************************************
    // checks
    // ****************************************
    property p_tap_reset;
        @(posedge clk) disable iff (!rst_b)
        !tap_rst_b |=> (state == S_TLR);
    endproperty
    a_tap_reset: assert property (p_tap_reset) // RULE14
        else $error("test reset did not force the reset state");

    property p_tap_step;
        @(posedge clk) disable iff (!rst_b)
        (tap_rst_b && step && state == S_SELDR && !tms) |=> (state == S_CAPDR);
    endproperty
    a_tap_step: assert property (p_tap_step) // RULE14
        else $error("select-dr did not move to capture-dr");

    property p_tap_hold;
        @(posedge clk) disable iff (!rst_b)
        (tap_rst_b && !step) |=> $stable(state);
    endproperty
    a_tap_hold: assert property (p_tap_hold) // RULE14
        else $error("controller moved without a test clock rise");

endmodule : bts_tap_fsm

/* File: bts_test_port.sv */
// boundary-scan test port: instruction decode, data registers and pin control
// Contract
// RULE1: code 0000 drives boundary cells onto outputs and scans the pin cell chain.
// RULE2: code 1111 puts the one-bit passthrough alone between data in and out.
// RULE3: code 0010 loads the fixed identity word and scans it out.
// RULE4: code 0100 floats every functional output and scans the passthrough bit.
// RULE5: code 0011 keeps driving boundary cells while scanning the passthrough bit.
// RULE6: code 0001 scans the chain and captures present pin levels for shift-out.
// RULE7: code 0001 also preloads shifted-in values into the boundary cells.
// RULE8: the tester loads only the six defined instruction codes.
// RULE9: identity word is 32 bits: revision 31:28, part 27:12, maker 11:1.
// RULE10: identity word bit 0 is always one.
// RULE11: test pins and test data out stay outside chain capture and forcing.
// RULE12: the tester runs the test clock at 10MHz, period at least 100 ns; the tester model runs it at 5MHz, period 200 ns.
// RULE13: no scan work while a port sleep request is asserted; the port has no sleep request input.
// RULE14: standard sixteen-state controller; test reset forces reset state and identity code.
// RULE15: chain length is a constant; instruction capture loads 01 in low bits.
`timescale 1ns/10ps
module bts_test_port
    import bts_pkg::*;
#(
    parameter logic [3:0]  ID_REV  = bts_pkg::ID_REV_DEF,  // arbitrary value
    parameter logic [15:0] ID_PART = bts_pkg::ID_PART_DEF, // arbitrary value
    parameter logic [10:0] ID_MFR  = bts_pkg::ID_MFR_DEF   // arbitrary value
)
(
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   tck,
    input  wire logic                   tms,
    input  wire logic                   tdi,
    input  wire logic                   trst_b,
    output logic                        tdo,
    output logic                        tdo_oe,
    input  wire logic [bts_pkg::IN_W-1:0]  func_in,
    input  wire logic [bts_pkg::OUT_W-1:0] core_out,
    input  wire logic [bts_pkg::OUT_W-1:0] core_oe,
    output logic      [bts_pkg::OUT_W-1:0] pin_out,
    output logic      [bts_pkg::OUT_W-1:0] pin_oe
);
    import bts_pkg::*;

    localparam logic [ID_W-1:0] ID_VALUE = {ID_REV, ID_PART, ID_MFR, ID_MARK}; // RULE9 RULE10

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic              tck_s1, tck_s2, tck_s3;
    logic              tms_s1, tms_s2;
    logic              tdi_s1, tdi_s2;
    logic              trst_s1, trst_s2;
    logic [IN_W-1:0]   fin_s1, fin_s2;
    logic              tck_rise, tck_fall;

    // two flops on every pin, a third on the clock for edge finding
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tck_s1  <= 1'b1;
            tck_s2  <= 1'b1;
            tck_s3  <= 1'b1;    // idle level, so no false edge follows reset
            tms_s1  <= 1'b1;
            tms_s2  <= 1'b1;
            tdi_s1  <= 1'b1;
            tdi_s2  <= 1'b1;
            trst_s1 <= 1'b0;
            trst_s2 <= 1'b0;
            fin_s1  <= '0;
            fin_s2  <= '0;
        end
        else
        begin
            tck_s1  <= tck;
            tck_s2  <= tck_s1;
            tck_s3  <= tck_s2;
            tms_s1  <= tms;
            tms_s2  <= tms_s1;
            tdi_s1  <= tdi;
            tdi_s2  <= tdi_s1;
            trst_s1 <= trst_b;
            trst_s2 <= trst_s1;
            fin_s1  <= func_in;
            fin_s2  <= fin_s1;
        end
    end

    assign tck_rise = tck_s2 & ~tck_s3;
    assign tck_fall = ~tck_s2 & tck_s3;

    // ****************************************
    // controller
    // ****************************************
    bts_tap_state_t tap_state;

    bts_tap_fsm u_fsm (
        .clk       (clk),
        .rst_b     (rst_b),
        .tap_rst_b (trst_s2),
        .step      (tck_rise),
        .tms       (tms_s2),
        .state     (tap_state)
    );

    // ****************************************
    // instruction and data registers
    // ****************************************
    logic [IR_W-1:0]      ir_shift, next_ir_shift;
    logic [IR_W-1:0]      ir, next_ir;
    logic                 single_bit_passthrough, next_single_bit_passthrough;
    logic [ID_W-1:0]      identity_word_reg, next_identity_word_reg;
    logic [CHAIN_LEN-1:0] pin_cell_chain, next_pin_cell_chain;
    logic [CHAIN_LEN-1:0] cell_hold, next_cell_hold;     // update stage of the chain
    logic                 next_tdo, next_tdo_oe;
    logic                 dr_lsb;

    // bit presented at data out while shifting a data register
    always_comb
    begin
        if (ir == C_IDCODE)
            dr_lsb = identity_word_reg[0];                // RULE3
        else if (bts_sel_chain(ir))
            dr_lsb = pin_cell_chain[0];                   // RULE1 RULE6
        else
            dr_lsb = single_bit_passthrough;              // RULE2 RULE4 RULE5
    end

    // capture and shift on test clock rises, update and data out on falls
    always_comb
    begin
        next_ir_shift               = ir_shift;
        next_ir                     = ir;
        next_single_bit_passthrough = single_bit_passthrough;
        next_identity_word_reg      = identity_word_reg;
        next_pin_cell_chain         = pin_cell_chain;
        next_cell_hold              = cell_hold;
        next_tdo                    = tdo;
        next_tdo_oe                 = tdo_oe;
        if (tap_state == S_TLR)
            next_ir = C_IDCODE;                                        // RULE14
        if (tck_rise)
        begin
            if (tap_state == S_CAPIR)
                next_ir_shift = IR_CAPT;                               // RULE15
            else if (tap_state == S_SHIR)
                next_ir_shift = {tdi_s2, ir_shift[IR_W-1:1]};
            else if (tap_state == S_CAPDR)
            begin
                next_single_bit_passthrough = 1'b0;
                if (ir == C_IDCODE)
                    next_identity_word_reg = ID_VALUE;                 // RULE3
                if (bts_sel_chain(ir))
                    next_pin_cell_chain = {pin_oe[0], pin_out, fin_s2}; // RULE6 RULE11
            end
            else if (tap_state == S_SHDR)
            begin
                if (ir == C_IDCODE)
                    next_identity_word_reg = {tdi_s2, identity_word_reg[ID_W-1:1]};
                else if (bts_sel_chain(ir))
                    next_pin_cell_chain = {tdi_s2, pin_cell_chain[CHAIN_LEN-1:1]}; // RULE7
                else
                    next_single_bit_passthrough = tdi_s2;              // RULE2
            end
        end
        if (tck_fall)
        begin
            if (tap_state == S_UPIR)
                next_ir = ir_shift;
            if (tap_state == S_UPDR && bts_sel_chain(ir))
                next_cell_hold = pin_cell_chain;                       // RULE7
            next_tdo_oe = (tap_state == S_SHIR) || (tap_state == S_SHDR);
            next_tdo    = (tap_state == S_SHIR) ? ir_shift[0] : dr_lsb;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ir_shift               <= IR_CAPT;
            ir                     <= C_IDCODE;
            single_bit_passthrough <= 1'b0;
            identity_word_reg      <= ID_VALUE;
            pin_cell_chain         <= CHAIN_RST;
            cell_hold              <= CHAIN_RST;
            tdo                    <= 1'b0;
            tdo_oe                 <= 1'b0;
        end
        else
        begin
            ir_shift               <= next_ir_shift;
            ir                     <= next_ir;
            single_bit_passthrough <= next_single_bit_passthrough;
            identity_word_reg      <= next_identity_word_reg;
            pin_cell_chain         <= next_pin_cell_chain;
            cell_hold              <= next_cell_hold;
            tdo                    <= next_tdo;
            tdo_oe                 <= next_tdo_oe;
        end
    end

    // ****************************************
    // functional pin control
    // ****************************************
    logic [OUT_W-1:0] next_pin_out, next_pin_oe;

    // forcing touches only functional outputs, never data out
    always_comb
    begin
        next_pin_out = core_out;
        next_pin_oe  = core_oe;
        if (bts_drive_cells(ir))
        begin
            next_pin_out = cell_hold[OUT_MSB:OUT_LSB];       // RULE1 RULE5 RULE11
            next_pin_oe  = {OUT_W{cell_hold[CTRL_POS]}};     // RULE1 RULE5
        end
        else if (ir == C_HIGHZ)
            next_pin_oe = '0;                                // RULE4
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_out <= '0;
            pin_oe  <= '0;
        end
        else
        begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_extest_drive;
        (ir == C_EXTEST) ##1 (ir == C_EXTEST) |->
            (pin_out == $past(cell_hold[OUT_MSB:OUT_LSB]))
            && (pin_oe == {OUT_W{$past(cell_hold[CTRL_POS])}});
    endproperty
    a_extest_drive: assert property (p_extest_drive) // RULE1
        else $error("boundary cells not driven onto outputs");

    property p_bypass_out;
        (ir == C_BYPASS && tap_state == S_SHDR && tck_fall) |=>
            (tdo == $past(single_bit_passthrough)) && tdo_oe;
    endproperty
    a_bypass_out: assert property (p_bypass_out) // RULE2
        else $error("data out did not follow the passthrough bit");

    property p_id_capture;
        (ir == C_IDCODE && tap_state == S_CAPDR && tck_rise) |=>
            (identity_word_reg[ID_W-1:REV_LSB] == ID_REV)
            && (identity_word_reg[REV_LSB-1:PART_LSB] == ID_PART)
            && (identity_word_reg[PART_LSB-1:MFR_LSB] == ID_MFR);
    endproperty
    a_id_capture: assert property (p_id_capture) // RULE3
        else $error("identity word fields wrong after capture");

    property p_id_mark;
        (ir == C_IDCODE && tap_state == S_CAPDR && tck_rise) |=> identity_word_reg[0];
    endproperty
    a_id_mark: assert property (p_id_mark) // RULE10
        else $error("identity marker bit not one");

    property p_highz;
        (ir == C_HIGHZ) |=> (pin_oe == '0);
    endproperty
    a_highz: assert property (p_highz) // RULE4
        else $error("outputs not floated");

    property p_clamp_path;
        (ir == C_CLAMP && tap_state == S_SHDR && tck_rise) |=>
            $stable(pin_cell_chain) && (single_bit_passthrough == $past(tdi_s2));
    endproperty
    a_clamp_path: assert property (p_clamp_path) // RULE5
        else $error("clamp did not shift through the passthrough bit");

    property p_sample;
        (ir == C_SAMPLE && tap_state == S_CAPDR && tck_rise) |=>
            (pin_cell_chain == {$past(pin_oe[0]), $past(pin_out), $past(fin_s2)});
    endproperty
    a_sample: assert property (p_sample) // RULE6
        else $error("sample did not capture pin levels");

    property p_preload;
        (ir == C_SAMPLE && tap_state == S_UPDR && tck_fall) |=>
            (cell_hold == $past(pin_cell_chain));
    endproperty
    a_preload: assert property (p_preload) // RULE7
        else $error("preload not moved into the update stage");

    property p_trst_ir;
        (!trst_s2) ##1 (!trst_s2) |=> (ir == C_IDCODE);
    endproperty
    a_trst_ir: assert property (p_trst_ir) // RULE14
        else $error("test reset did not select the identity instruction");

    property p_ir_capture;
        (tap_state == S_CAPIR && tck_rise) |=> (ir_shift[1:0] == 2'b01);
    endproperty
    a_ir_capture: assert property (p_ir_capture) // RULE15
        else $error("instruction capture pattern wrong");

    c_id_shift: cover property (ir == C_IDCODE && tap_state == S_SHDR && tck_fall);
    c_extest:   cover property (ir == C_EXTEST && tap_state == S_UPDR && tck_fall);
    c_highz:    cover property (ir == C_CLAMP ##1 ir == C_HIGHZ);

endmodule : bts_test_port

/* File: bts_tester.sv */
// test controller model: drives test clock, mode select, data in and test reset
`timescale 1ns/10ps
module bts_tester
(
    input  wire logic clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_b,
    input  wire logic tdo
);
    // ****************************************
    // pin drive, test clock idles high between frames
    // ****************************************
    // the model never raises a port sleep request while scanning
    initial
    begin
        tck    = 1'b1;
        tms    = 1'b1;
        tdi    = 1'b0;
        trst_b = 1'b0;
    end

    // one test clock period of 8 clk (200 ns): low half then high half
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge clk);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        q   = tdo;
        tck = 1'b1;
        repeat (3) @(negedge clk);
    endtask : step

    // pulse test reset, then walk to run-test/idle
    task automatic tap_reset();
        logic q;
        @(negedge clk);
        trst_b = 1'b0;
        repeat (8) @(negedge clk);
        trst_b = 1'b1;
        repeat (8) @(negedge clk);
        step(1'b0, 1'b0, q);
    endtask : tap_reset

    // one scan from idle to idle, lsb first; update lands on the last fall
    task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        step(1'b1, 1'b0, q);
        if (is_ir)
            step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        dout = '0;
        for (int k = 0; k < n; k++)
        begin
            step(k == n - 1, din[k], q);
            dout[k] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : scan
endmodule : bts_tester

/* File: tb.sv */
// self-checking testbench for the boundary-scan test port
`timescale 1ns/10ps
module tb;
    import bts_pkg::*;

    // ****************************************
    // signals, design and tester
    // ****************************************
    localparam int LIMIT = 20000;
    localparam logic [31:0] ID_EXP = {ID_REV_DEF, ID_PART_DEF, ID_MFR_DEF, ID_MARK};
    logic             clk;
    logic             rst_b;
    logic             tck;
    logic             tms;
    logic             tdi;
    logic             trst_b;
    logic             tdo;
    logic             tdo_oe;
    logic [IN_W-1:0]  func_in;
    logic [OUT_W-1:0] core_out;
    logic [OUT_W-1:0] core_oe;
    logic [OUT_W-1:0] pin_out;
    logic [OUT_W-1:0] pin_oe;
    logic [31:0]      got;
    int               err_count = 0;
    int               cmp_count = 0;
    int               cycles = 0;

    bts_test_port u_bts_test_port (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_b(trst_b), .tdo(tdo), .tdo_oe(tdo_oe), .func_in(func_in),
        .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));

    bts_tester u_bts_tester (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_b(trst_b), .tdo(tdo));

    // ****************************************
    // helpers
    // ****************************************
    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // load an instruction; its capture shifts out first
    task automatic load(input logic [IR_W-1:0] code);
        u_bts_tester.scan(1'b1, IR_W, 32'(code), got);
        check("instruction capture", got[1:0], 2'b01);
    endtask : load

    // pin state and released data out while idle
    task automatic pins(input logic [7:0] exp_out, input logic [7:0] exp_oe);
        check("pin_out", pin_out, exp_out);
        check("pin_oe", pin_oe, exp_oe);
        check("tdo_oe at rest", tdo_oe, 1'b0);
    endtask : pins

    // one-bit path: captured zero, then data in delayed by one
    task automatic through_bypass();
        u_bts_tester.scan(1'b0, 8, 32'h0000_00b6, got);
        check("passthrough shift", got[7:0], 8'h6c);
    endtask : through_bypass

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_identity();
        u_bts_tester.tap_reset();
        u_bts_tester.scan(1'b0, ID_W, 32'h0, got);
        check("identity word", got, ID_EXP);
        pins(core_out, core_oe);
    endtask : t_identity

    // bypass, then a test reset in mid run brings the identity code back
    task automatic t_bypass();
        load(C_BYPASS);
        through_bypass();
        pins(core_out, core_oe);
        u_bts_tester.tap_reset();
        u_bts_tester.scan(1'b0, ID_W, 32'h0, got);
        check("identity after test reset", got, ID_EXP);
    endtask : t_bypass

    // sample pin levels while preloading drive values
    task automatic t_sample();
        @(negedge clk);
        core_out = 8'ha5;
        core_oe  = 8'h0f;
        load(C_SAMPLE);
        u_bts_tester.scan(1'b0, CHAIN_LEN, 32'h0001_9600, got);
        check("sampled chain", got[CHAIN_LEN-1:0], 17'h1_a53c);
        pins(8'ha5, 8'h0f);
    endtask : t_sample

    // cells drive pins, then clamp and float
    task automatic t_drive();
        load(C_EXTEST);
        pins(8'h96, 8'hff);
        u_bts_tester.scan(1'b0, CHAIN_LEN, 32'h0001_5a00, got);
        check("chain under drive", got[CHAIN_LEN-1:0], 17'h1_963c);
        pins(8'h5a, 8'hff);
        load(C_CLAMP);
        pins(8'h5a, 8'hff);
        through_bypass();
        load(C_HIGHZ);
        pins(core_out, 8'h00);
        through_bypass();
    endtask : t_drive

    // ****************************************
    // clock, sequence, timeout and verdict
    // ****************************************
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        rst_b    = 1'b0;
        func_in  = 8'h3c;
        core_out = 8'hc3;
        core_oe  = 8'hf0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        t_identity();
        t_bypass();
        t_sample();
        t_drive();
        wrap_up();
    end

    // cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            err_count++;
            wrap_up();
        end
    end
endmodule : tb
